// >>> hdl/dcr_device_config_map.vh
// Constants for the device configuration register block: offsets, fields,
// reset values and timing figures.
// Assumes the includer runs on a 125 MHz clock and a 16-bit register port.
`ifndef DCR_DEVICE_CONFIG_MAP_VH
`define DCR_DEVICE_CONFIG_MAP_VH

`define DCR_ADDR_W 4
`define DCR_OFS_SWITCH_STATE 4'h7
`define DCR_OFS_DEVICE_CONFIGURATION 4'h9

`define DCR_SWITCH_STATE_RESET 16'hfffc
`define DCR_DEVICE_CONFIGURATION_RESET 16'hf800
`define DCR_CFG_RSVD_ONES 5'h1f
`define DCR_SW_RSVD_ONES 14'h3fff
`define DCR_UNMAPPED_READ 16'h0000

`define DCR_F_SECOND_FB_HI 10
`define DCR_F_SECOND_FB_LO 9
`define DCR_F_FIRST_FB_HI 8
`define DCR_F_FIRST_FB_LO 7
`define DCR_F_PWM_STAGGER_DIS 6
`define DCR_F_AUTO_SLEEP_EN 5
`define DCR_F_PARALLEL 4
`define DCR_F_GUARD_EN 3
`define DCR_F_PERIOD_HI 2
`define DCR_F_PERIOD_LO 1

`define DCR_FB_PIN 2'h0
`define DCR_FB_HOLD 2'h1
`define DCR_FB_OFF 2'h2
`define DCR_FB_ON 2'h3

`define DCR_CLK_MHZ 125
`define DCR_T_STAGGER_US 100
`define DCR_T_WIN0_US 400
`define DCR_T_WIN1_MS 400
`define DCR_T_WIN2_MS 800
`define DCR_T_WIN3_MS 1200

`endif

// >>> hdl/dcr_sync2.v
// Two-flop synchroniser for the two channel input pins.
// Assumes the pins are asynchronous to ref_clk and slow against it.
`timescale 1ns/1ps
module dcr_sync2
(
    ref_clk,
    rst_b,
    async_in,
    sync_q
);
    input wire ref_clk;
    input wire rst_b;
    input wire [1:0] async_in;
    output wire [1:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end
                else
                begin
                    meta_q <= async_in[g];
                    stable_q <= meta_q;
                end
            end
            assign sync_q[g] = stable_q;
        end
    endgenerate
endmodule

// >>> hdl/dcr_link_guard.v
// Serial-link timeout guard: counts cycles since the last valid command.
// Assumes valid_cmd is a one-cycle pulse from the command decoder on ref_clk.
`timescale 1ns/1ps
module dcr_link_guard
#(
    parameter [27:0] WIN0_CYC = 28'd50000,
    parameter [27:0] WIN1_CYC = 28'd50000000,
    parameter [27:0] WIN2_CYC = 28'd100000000,
    parameter [27:0] WIN3_CYC = 28'd150000000
)
(
    ref_clk,
    rst_b,
    enable,
    period_sel,
    valid_cmd,
    expired_q
);
    input wire ref_clk;
    input wire rst_b;
    input wire enable;
    input wire [1:0] period_sel;
    input wire valid_cmd;
    output reg expired_q;

    reg [27:0] cnt_q;
    reg [1:0] sel_q;
    reg [27:0] limit;
    wire restart;
    wire hit;

    always @*
    begin
        case (period_sel)
            2'h0: limit = WIN0_CYC;
            2'h1: limit = WIN1_CYC;
            2'h2: limit = WIN2_CYC;
            2'h3: limit = WIN3_CYC;
            default: limit = WIN0_CYC;
        endcase
    end

    // A new period selection starts a fresh window, so a shorter window
    // picked late cannot fire on time already spent under the old one.
    assign restart = valid_cmd || !enable || (sel_q != period_sel);
    assign hit = enable && (sel_q == period_sel) &&
        (cnt_q >= limit - 28'd1);

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 28'h0000000;
            sel_q <= 2'h0;
            expired_q <= 1'b0;
        end
        else
        begin
            sel_q <= period_sel;
            if (restart || hit)
                cnt_q <= 28'h0000000;
            else
                cnt_q <= cnt_q + 28'd1;
            // Expiry beats a clearing command in the same cycle.
            if (hit)
                expired_q <= 1'b1;
            else if (valid_cmd || !enable)
                expired_q <= 1'b0;
        end
    end
endmodule

// >>> hdl/dcr_device_config.v
// Device configuration and switch-state registers with the logic they steer:
// fallback output selection, PWM start stagger, sleep entry gate, parallel
// mode and the serial-link timeout guard.
// Assumes an SPI frame decoder on ref_clk presents a 16-bit register port
// with one-cycle read and write strobes and a valid-command pulse.
`timescale 1ns/1ps
`include "dcr_device_config_map.vh"
module dcr_device_config
#(
    parameter HAS_FALLBACK = 1,
    parameter [13:0] STAGGER_CYC = `DCR_T_STAGGER_US * `DCR_CLK_MHZ,
    parameter [27:0] WIN0_CYC = `DCR_T_WIN0_US * `DCR_CLK_MHZ,
    parameter [27:0] WIN1_CYC = `DCR_T_WIN1_MS * 1000 * `DCR_CLK_MHZ,
    parameter [27:0] WIN2_CYC = `DCR_T_WIN2_MS * 1000 * `DCR_CLK_MHZ,
    parameter [27:0] WIN3_CYC = `DCR_T_WIN3_MS * 1000 * `DCR_CLK_MHZ
)
(
    ref_clk,
    rst_b,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata_q,
    reg_rvalid_q,
    valid_cmd,
    channel_input_pin,
    fallback_state,
    sleep_conditions_met,
    pwm_in,
    channel_on_q,
    pwm_out_q,
    automatic_sleep_state_q,
    parallel_mode_q,
    parallel_write_refused_q,
    link_timeout_q
);
    input wire ref_clk;
    input wire rst_b;
    input wire [3:0] reg_addr;
    input wire [15:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [15:0] reg_rdata_q;
    output reg reg_rvalid_q;
    input wire valid_cmd;
    input wire [1:0] channel_input_pin;
    input wire fallback_state;
    input wire sleep_conditions_met;
    input wire [1:0] pwm_in;
    output reg [1:0] channel_on_q;
    output reg [1:0] pwm_out_q;
    output reg automatic_sleep_state_q;
    output reg parallel_mode_q;
    output reg parallel_write_refused_q;
    output wire link_timeout_q;

    // Configuration bits 10 down to 1 are stored; bit 0 is not part of
    // this block and reads as zero.
    reg [10:1] cfg_q;
    reg [10:1] cfg_d;
    reg [1:0] switch_state_register_q;
    reg [1:0] frozen_q;
    reg fallback_q;
    reg stagger_armed_q;
    reg stagger_busy_q;
    reg [13:0] stagger_cnt_q;
    reg [15:0] rdata_d;
    wire [1:0] chan_d;
    localparam [15:0] CFG_RESET = `DCR_DEVICE_CONFIGURATION_RESET;

    wire wr_cfg;
    wire wr_sw;
    wire both_off;
    wire fallback_entry;
    wire [1:0] pin_sync;
    wire [1:0] second_channel_fallback_select;
    wire [1:0] first_channel_fallback_select;
    wire pwm_stagger_disable;
    wire automatic_sleep_entry_enable;
    wire link_timeout_guard_enable;
    wire [1:0] link_timeout_period_select;
    wire second_rise;

    assign wr_cfg = reg_wr && (reg_addr == `DCR_OFS_DEVICE_CONFIGURATION);
    assign wr_sw = reg_wr && (reg_addr == `DCR_OFS_SWITCH_STATE);
    assign both_off = (switch_state_register_q == 2'h0);

    assign second_channel_fallback_select =
        cfg_q[`DCR_F_SECOND_FB_HI:`DCR_F_SECOND_FB_LO];
    assign first_channel_fallback_select =
        cfg_q[`DCR_F_FIRST_FB_HI:`DCR_F_FIRST_FB_LO];
    assign pwm_stagger_disable = cfg_q[`DCR_F_PWM_STAGGER_DIS];
    assign automatic_sleep_entry_enable = cfg_q[`DCR_F_AUTO_SLEEP_EN];
    assign link_timeout_guard_enable = cfg_q[`DCR_F_GUARD_EN];
    assign link_timeout_period_select =
        cfg_q[`DCR_F_PERIOD_HI:`DCR_F_PERIOD_LO];

    dcr_sync2 u_pin_sync
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(channel_input_pin),
        .sync_q(pin_sync)
    );

    dcr_link_guard
    #(
        .WIN0_CYC(WIN0_CYC),
        .WIN1_CYC(WIN1_CYC),
        .WIN2_CYC(WIN2_CYC),
        .WIN3_CYC(WIN3_CYC)
    )
    u_guard
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .enable(link_timeout_guard_enable),
        .period_sel(link_timeout_period_select),
        .valid_cmd(valid_cmd),
        .expired_q(link_timeout_q)
    );

    // Next configuration value; the parallel bit keeps its old value when
    // either channel is switched on, so a load is never re-paired live.
    always @*
    begin
        cfg_d = cfg_q;
        if (wr_cfg)
        begin
            cfg_d[10:5] = reg_wdata[10:5];
            cfg_d[3:1] = reg_wdata[3:1];
            if (both_off)
                cfg_d[`DCR_F_PARALLEL] = reg_wdata[`DCR_F_PARALLEL];
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_q <= CFG_RESET[10:1];
            switch_state_register_q <= 2'h0;
            parallel_write_refused_q <= 1'b0;
            parallel_mode_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            if (wr_sw)
                switch_state_register_q <= reg_wdata[1:0];
            // Pulse for a refused attempt to change the parallel bit.
            parallel_write_refused_q <= wr_cfg && !both_off &&
                (reg_wdata[`DCR_F_PARALLEL] != cfg_q[`DCR_F_PARALLEL]);
            parallel_mode_q <= cfg_d[`DCR_F_PARALLEL];
        end
    end

    // Read port: reserved bits are forced high regardless of what was
    // written, and unmapped offsets answer with all zeros.
    always @*
    begin
        case (reg_addr)
            `DCR_OFS_DEVICE_CONFIGURATION:
                rdata_d = {`DCR_CFG_RSVD_ONES, cfg_q[10:1], 1'b0};
            `DCR_OFS_SWITCH_STATE:
                rdata_d = {`DCR_SW_RSVD_ONES, switch_state_register_q};
            default:
                rdata_d = `DCR_UNMAPPED_READ;
        endcase
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rdata_d;
        end
    end

    // Fallback tracking: the switch bits are captured on the cycle the
    // fallback state is entered.
    assign fallback_entry = fallback_state && !fallback_q;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fallback_q <= 1'b0;
            frozen_q <= 2'h0;
        end
        else
        begin
            fallback_q <= fallback_state;
            if (fallback_entry)
                frozen_q <= switch_state_register_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_chan
            wire [1:0] sel;
            wire held;
            reg out_d;
            assign sel = (g == 0) ? first_channel_fallback_select :
                second_channel_fallback_select;
            // On the entry cycle the capture is not yet visible in
            // frozen_q, so the live switch bit stands in for it.
            assign held = fallback_entry ? switch_state_register_q[g] :
                frozen_q[g];
            always @*
            begin
                out_d = switch_state_register_q[g];
                if (HAS_FALLBACK != 0 && fallback_state)
                begin
                    case (sel)
                        `DCR_FB_PIN: out_d = pin_sync[g];
                        `DCR_FB_HOLD: out_d = held;
                        `DCR_FB_OFF: out_d = 1'b0;
                        `DCR_FB_ON: out_d = 1'b1;
                        default: out_d = 1'b0;
                    endcase
                end
            end
            assign chan_d[g] = out_d;
        end
    endgenerate

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            channel_on_q <= 2'h0;
        else
            channel_on_q <= chan_d;
    end

    // PWM stagger: while both PWM inputs are idle the stagger is armed, and
    // the next rising edge of the second channel is held back by the
    // stagger time. Later edges pass through, so the offset is kept
    // without stretching every pulse.
    assign second_rise = pwm_in[1] && !pwm_out_q[1] && !stagger_busy_q;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwm_out_q <= 2'h0;
            stagger_armed_q <= 1'b1;
            stagger_busy_q <= 1'b0;
            stagger_cnt_q <= 14'h0000;
        end
        else
        begin
            pwm_out_q[0] <= pwm_in[0];
            if (pwm_in == 2'h0 && !stagger_busy_q)
                stagger_armed_q <= 1'b1;
            if (stagger_busy_q)
            begin
                if (!pwm_in[1] || pwm_stagger_disable)
                begin
                    stagger_busy_q <= 1'b0;
                    pwm_out_q[1] <= pwm_in[1];
                end
                else if (stagger_cnt_q >= STAGGER_CYC - 14'd1)
                begin
                    stagger_busy_q <= 1'b0;
                    pwm_out_q[1] <= 1'b1;
                end
                else
                    stagger_cnt_q <= stagger_cnt_q + 14'd1;
            end
            else if (second_rise && stagger_armed_q && !pwm_stagger_disable)
            begin
                stagger_armed_q <= 1'b0;
                stagger_busy_q <= 1'b1;
                // Counting from zero makes the hold exactly STAGGER_CYC
                // cycles longer than the undelayed one-cycle path.
                stagger_cnt_q <= 14'h0000;
            end
            else
            begin
                if (second_rise)
                    stagger_armed_q <= 1'b0;
                pwm_out_q[1] <= pwm_in[1];
            end
        end
    end

    // Sleep entry request is only a gate; the sleep sequencer owns the
    // actual state change and the conditions behind it.
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            automatic_sleep_state_q <= 1'b0;
        else
            automatic_sleep_state_q <= automatic_sleep_entry_enable &&
                sleep_conditions_met;
    end
endmodule

// >>> verification/dcr_checker.sv
// Port checker for the configuration register block.
// Assumes the read strobe stays low while reset is applied.
`timescale 1ns/1ps
module dcr_checker
(
    input logic ref_clk,
    input logic rst_b,
    input logic [3:0] reg_addr,
    input logic reg_rd,
    input logic [15:0] reg_rdata_q,
    input logic reg_rvalid_q,
    input logic valid_cmd,
    input logic sleep_conditions_met,
    input logic automatic_sleep_state_q,
    input logic [1:0] pwm_in,
    input logic [1:0] pwm_out_q,
    input logic parallel_mode_q,
    input logic parallel_write_refused_q,
    input logic link_timeout_q
);
    int since_cmd;
    // Saturates so a long idle guard cannot wrap and look fresh.
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            since_cmd <= 0;
        else if (valid_cmd)
            since_cmd <= 0;
        else if (since_cmd < 1000)
            since_cmd <= since_cmd + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_taken;
        reg_rd;
    endsequence
    sequence cfg_answer;
        reg_rvalid_q && $past(reg_addr) == 4'h9;
    endsequence
    read_answer_a: assert property (rd_taken |=> reg_rvalid_q)
        else $error("read answer missing");
    no_stray_answer_a: assert property (!reg_rd |=> !reg_rvalid_q)
        else $error("answer without read");
    reserved_ones_a: assert property (cfg_answer |->
        reg_rdata_q[15:11] == 5'h1f) else $error("reserved bits not ones");
    rdata_hold_a: assert property (!reg_rvalid_q |->
        $stable(reg_rdata_q)) else $error("read data moved without read");
    sleep_block_a: assert property (!sleep_conditions_met |=>
        !automatic_sleep_state_q) else $error("sleep without conditions");
    parallel_keep_a: assert property (parallel_write_refused_q |->
        $stable(parallel_mode_q)) else $error("refused write changed bit");
    timeout_quiet_a: assert property ($rose(link_timeout_q) |->
        since_cmd >= 15) else $error("timeout too early");
    pwm_first_a: assert property (pwm_out_q[0] == $past(pwm_in[0]))
        else $error("first pwm not one cycle late");
    pwm_cause_a: assert property ($rose(pwm_out_q[1]) |->
        $past(pwm_in[1])) else $error("second pwm rose unprompted");
endmodule
bind dcr_device_config dcr_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .valid_cmd(valid_cmd),
    .sleep_conditions_met(sleep_conditions_met),
    .automatic_sleep_state_q(automatic_sleep_state_q), .pwm_in(pwm_in),
    .pwm_out_q(pwm_out_q), .parallel_mode_q(parallel_mode_q),
    .parallel_write_refused_q(parallel_write_refused_q),
    .link_timeout_q(link_timeout_q));

// >>> verification/dcr_host_model.sv
// Host model that drives the register strobe port.
// Assumes a read is answered exactly one cycle after its strobe.
`timescale 1ns/1ps
module dcr_host_model
(
    input logic ref_clk,
    output logic [3:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input logic [15:0] reg_rdata_q,
    input logic reg_rvalid_q
);
    initial
    begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Data is inverted once released so a stale bus cannot pass a check.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d,
        output logic ok);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
        ok = reg_rvalid_q;
    endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the configuration register block.
// Assumes short timing parameters so every window fits a brief run.
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic valid_cmd = 1'b0;
    logic [1:0] channel_input_pin = 2'h0;
    logic fallback_state = 1'b0;
    logic sleep_conditions_met = 1'b0;
    logic [1:0] pwm_in = 2'h0;
    wire [3:0] reg_addr;
    wire [15:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    wire [15:0] reg_rdata_q;
    wire reg_rvalid_q;
    wire [1:0] channel_on_q;
    wire [1:0] pwm_out_q;
    wire automatic_sleep_state_q;
    wire parallel_mode_q;
    wire parallel_write_refused_q;
    wire link_timeout_q;
    wire [1:0] nofb_on_q;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 10;
    int n;
    logic [15:0] d;
    logic ok;
    always #4 ref_clk = ~ref_clk;
    dcr_device_config #(.STAGGER_CYC(14'd10), .WIN0_CYC(28'd20),
        .WIN1_CYC(28'd40), .WIN2_CYC(28'd60), .WIN3_CYC(28'd80)) dut
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q),
        .valid_cmd(valid_cmd),
        .channel_input_pin(channel_input_pin),
        .fallback_state(fallback_state),
        .sleep_conditions_met(sleep_conditions_met),
        .pwm_in(pwm_in),
        .channel_on_q(channel_on_q),
        .pwm_out_q(pwm_out_q),
        .automatic_sleep_state_q(automatic_sleep_state_q),
        .parallel_mode_q(parallel_mode_q),
        .parallel_write_refused_q(parallel_write_refused_q),
        .link_timeout_q(link_timeout_q)
    );
    // Variant without a fallback state: its outputs must follow the
    // switch bits even while fallback_state is high.
    dcr_device_config #(.HAS_FALLBACK(0)) dut_nofb
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_q(),
        .reg_rvalid_q(),
        .valid_cmd(valid_cmd),
        .channel_input_pin(channel_input_pin),
        .fallback_state(fallback_state),
        .sleep_conditions_met(sleep_conditions_met),
        .pwm_in(pwm_in),
        .channel_on_q(nofb_on_q),
        .pwm_out_q(),
        .automatic_sleep_state_q(),
        .parallel_mode_q(),
        .parallel_write_refused_q(),
        .link_timeout_q()
    );
    dcr_host_model host
    (
        .ref_clk(ref_clk),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q)
    );
    function automatic logic [15:0] cfg_exp(input logic [15:0] w);
        cfg_exp = (w & 16'h07fe) | 16'hf800;
    endfunction
    function automatic logic [1:0] fb_exp(input logic [1:0] c,
        input logic [1:0] p, input logic [1:0] s);
        case (c)
            2'h0: fb_exp = p;
            2'h1: fb_exp = s;
            2'h2: fb_exp = 2'h0;
            default: fb_exp = 2'h3;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        host.rd(a, d, ok);
        chk("rvalid", 16'h1, {15'h0, ok});
        chk("rdata", exp, d);
    endtask
    task automatic pulse_cmd;
        @(posedge ref_clk);
        valid_cmd <= 1'b1;
        @(posedge ref_clk);
        valid_cmd <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(2);
        rdchk(4'h9, 16'hf800);
        rdchk(4'h7, 16'hfffc);
        rdchk(4'h3, 16'h0000);
        repeat (16)
        begin
            n = $random(seed);
            host.wr(4'h9, n[15:0]);
            rdchk(4'h9, cfg_exp(n[15:0]));
        end
        host.wr(4'h9, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            n = $random(seed);
            host.wr(4'h7, {14'h0, n[1:0]});
            host.wr(4'h9, {5'h0, c[1:0], c[1:0], 7'h0});
            @(posedge ref_clk);
            channel_input_pin <= n[3:2];
            tick(4);
            chk("on", {14'h0, n[1:0]}, {14'h0, channel_on_q});
            @(posedge ref_clk);
            fallback_state <= 1'b1;
            tick(2);
            host.wr(4'h7, {14'h0, ~n[1:0]});
            tick(4);
            d = {14'h0, fb_exp(c[1:0], n[3:2], n[1:0])};
            chk("fb", d, {14'h0, channel_on_q});
            chk("nofb", {14'h0, ~n[1:0]}, {14'h0, nofb_on_q});
            @(posedge ref_clk);
            fallback_state <= 1'b0;
            host.wr(4'h7, 16'h0000);
        end
        host.wr(4'h9, 16'h0010);
        #1;
        chk("par", 16'h1, {15'h0, parallel_mode_q});
        host.wr(4'h7, 16'h0002);
        host.wr(4'h9, 16'h0000);
        #1;
        chk("refuse", 16'h1, {15'h0, parallel_write_refused_q});
        rdchk(4'h9, 16'hf810);
        host.wr(4'h7, 16'h0000);
        host.wr(4'h9, 16'h0000);
        @(posedge ref_clk);
        pwm_in <= 2'h3;
        tick(3);
        chk("stagger", 16'h1, {14'h0, pwm_out_q});
        tick(7);
        chk("stagger hold", 16'h1, {14'h0, pwm_out_q});
        tick(1);
        chk("stagger", 16'h3, {14'h0, pwm_out_q});
        pwm_in <= 2'h0;
        host.wr(4'h9, 16'h0040);
        pwm_in <= 2'h3;
        tick(2);
        chk("aligned", 16'h3, {14'h0, pwm_out_q});
        pwm_in <= 2'h0;
        for (int b = 0; b < 4; b++)
        begin
            host.wr(4'h9, {10'h0, b[1], 5'h0});
            sleep_conditions_met <= b[0];
            tick(2);
            d = {15'h0, b[1] & b[0]};
            chk("sleep", d, {15'h0, automatic_sleep_state_q});
        end
        for (int c = 0; c < 4; c++)
        begin
            host.wr(4'h9, {12'h0, 1'b1, c[1:0], 1'b0});
            pulse_cmd();
            n = 0;
            while (link_timeout_q !== 1'b1 && n < 200)
            begin
                tick(1);
                n++;
            end
            d = {15'h0, n == 20 * c + 20};
            chk("window", 16'h1, d);
            pulse_cmd();
            tick(1);
            chk("clear", 16'h0, {15'h0, link_timeout_q});
        end
        host.wr(4'h9, 16'h0000);
        tick(100);
        chk("guard off", 16'h0, {15'h0, link_timeout_q});
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule
